//--- rtl/reset_combiner_cfg.svh
// Constants for the reset source combiner: offsets, fields, reset values.
// Assumes inclusion by the combiner package, module and bench only.
`ifndef RESET_COMBINER_CFG_SVH
`define RESET_COMBINER_CFG_SVH

// Register byte offsets on the AHB-Lite slave
`define OFS_CAUSE     12'h000
`define OFS_FORCE     12'h004
`define OFS_IRQ_STAT  12'h008
`define OFS_IRQ_MASK  12'h00c
`define OFS_CONTROL   12'h010

// Cause flag positions in reset_cause_status
`define POS_POR       0
`define POS_BROWNOUT  1
`define POS_PIN       2
`define POS_INSTR     3
`define POS_WDOG      4
`define POS_CFGMIS    5
`define POS_TRAP      6
`define POS_ILLOP     7
`define POS_UWREG     8

// Reset values
`define CAUSE_POR_VAL 9'h003
`define CTRL_RST_VAL  16'h0000

// Cycles the master reset is stretched after all sources drop
`define STRETCH_CYC   4'h4

`endif

//--- rtl/reset_combiner_pkg.sv
// Types for the reset source combiner.
// Assumes the constants header sits beside it.
`include "reset_combiner_cfg.svh"
package reset_combiner_pkg;
  localparam int NSRC = 9;
  typedef logic [NSRC-1:0] src_vec_t;
  // AHB-Lite address phase capture
  typedef struct packed {
    logic        write;
    logic        sel;
    logic [11:0] addr;
  } bus_req_t;
  typedef enum logic [1:0] {ST_RUN, ST_HOLD, ST_STRETCH} seq_state_t;
endpackage

//--- rtl/reset_source_combiner.sv
// Reset source combiner with cause flags and AHB-Lite register slave.
// Assumes reset sources arrive asynchronous (pins, other logic) and that
// hresetn is the power-on reset of this block's own flops.
//
// Summary of operation
// RULE1 - Nine reset sources combine into one reset
// RULE2 - Master reset asserted while any source active
// RULE3 - Master reset drives defined register states
// RULE4 - Each reset sets its own cause flag
// RULE5 - Power-on clears flags, sets bits 1:0
// RULE6 - Software may set or clear any flag
// RULE7 - Software flag writes never cause reset
// RULE8 - Software should clear flags after reading
// RULE9 - Other resets set only their flag
`timescale 1ns/100ps
`include "reset_combiner_cfg.svh"
module reset_source_combiner
  import reset_combiner_pkg::*;
#(
  parameter int NUM_SOURCES = 9
) (
  // Clock and power-on reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Raw reset sources, active high, index by POS_ constants
  input  wire logic [8:0]  reset_sources,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Combined reset and interrupt
  output logic             master_system_reset,
  output logic             irq
);

  if (NUM_SOURCES != NSRC) begin : g_bad_width
    $error("Only nine reset sources supported");
  end

  // Two-flop synchroniser; first stage read by second stage only
  src_vec_t sync1;
  src_vec_t sync2;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= reset_sources;
      sync2 <= sync1;
    end
  end

  // Previous sample for rising-edge detection of each source
  src_vec_t prev_src;
  src_vec_t src_rise;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) prev_src <= '0;
    else          prev_src <= sync2;
  end
  assign src_rise = sync2 & ~prev_src;

  // Master reset sequencer: hold while any source, then stretch
  seq_state_t state;
  logic [3:0] stretch_cnt;
  logic       any_src;
  // RULE1 combine all sources
  assign any_src = |sync2;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state       <= ST_HOLD;
      stretch_cnt <= `STRETCH_CYC;
    end else begin
      unique case (state)
        ST_RUN: begin
          if (any_src) state <= ST_HOLD;
        end
        ST_HOLD: begin
          stretch_cnt <= `STRETCH_CYC;
          if (!any_src) state <= ST_STRETCH;
        end
        ST_STRETCH: begin
          if (any_src) state <= ST_HOLD;
          else if (stretch_cnt == 4'h1) state <= ST_RUN;
          else stretch_cnt <= stretch_cnt - 4'h1;
        end
      endcase
    end
  end

  // RULE2 reset output level
  // Registered; on from power-on so downstream sees reset at once
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) master_system_reset <= 1'b1;
    else master_system_reset <= any_src || (state != ST_RUN &&
      !(state == ST_STRETCH && stretch_cnt == 4'h1));
  end

  // AHB-Lite address phase capture; zero wait states
  bus_req_t req;
  logic     wr_go;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) req <= '0;
    else if (hready) begin
      req.sel   <= hsel && htrans[1];
      req.write <= hwrite;
      req.addr  <= haddr[11:0];
    end
  end
  assign wr_go = req.sel && req.write;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    return a == o;
  endfunction

  // Cause flags, set by hardware or software
  src_vec_t   reset_cause_status;
  src_vec_t   irq_stat;
  src_vec_t   irq_mask;
  logic [15:0] control;
  src_vec_t   next_cause;
  always_comb begin
    next_cause = reset_cause_status;
    // RULE6 software set or clear
    // RULE7 write touches flags only
    if (wr_go && hit(req.addr, `OFS_CAUSE))
      next_cause = hwdata[NSRC-1:0];
    // RULE4 hardware cause set
    // RULE9 only active flag set
    // Hardware set applied last so it wins over a same-cycle clear
    next_cause = next_cause | src_rise;
    // RULE5 power-on source restarts record
    // A power-on source wipes older causes, as a true power-up would
    if (src_rise[`POS_POR]) next_cause = `CAUSE_POR_VAL | src_rise;
  end
  // RULE5 power-on flag value
  // RULE3 defined state under reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) reset_cause_status <= `CAUSE_POR_VAL;
    else          reset_cause_status <= next_cause;
  end

  // Interrupt status: sticky, write one to clear, set wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) irq_stat <= '0;
    else if (wr_go && hit(req.addr, `OFS_IRQ_STAT))
      irq_stat <= (irq_stat & ~hwdata[NSRC-1:0]) | src_rise;
    else
      irq_stat <= irq_stat | src_rise;
  end

  // Mask and spare control word
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask <= '0;
      control  <= `CTRL_RST_VAL;
    end else if (wr_go) begin
      if (hit(req.addr, `OFS_IRQ_MASK)) irq_mask <= hwdata[NSRC-1:0];
      if (hit(req.addr, `OFS_CONTROL))  control  <= hwdata[15:0];
    end
  end

  // Level interrupt, registered
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) irq <= 1'b0;
    else irq <= |(irq_stat & irq_mask) | (|(src_rise & irq_mask));
  end

  // Read data registered in the address phase; unmapped reads zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hrdata <= '0;
    else if (hready && hsel && htrans[1] && !hwrite) begin
      unique case (haddr[11:0])
        `OFS_CAUSE:    hrdata <= {23'h0, next_cause};
        `OFS_FORCE:    hrdata <= {23'h0, sync2};
        `OFS_IRQ_STAT: hrdata <= {23'h0, irq_stat};
        `OFS_IRQ_MASK: hrdata <= {23'h0, irq_mask};
        `OFS_CONTROL:  hrdata <= {16'h0, control};
        default:       hrdata <= '0;
      endcase
    end
  end

  // Always ready, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Assertions
  chk_reset_follows: assert property ( // RULE2
    @(posedge hclk) disable iff (!hresetn)
    any_src |=> master_system_reset)
    else $error("Master reset not asserted with active source");
  chk_reset_release: assert property ( // RULE1
    @(posedge hclk) disable iff (!hresetn)
    (state == ST_RUN && !any_src) |=> !master_system_reset)
    else $error("Master reset stuck while idle");
  chk_cause_set: assert property ( // RULE4
    @(posedge hclk) disable iff (!hresetn)
    src_rise[`POS_WDOG] |=> reset_cause_status[`POS_WDOG])
    else $error("Watchdog cause flag not set");
  chk_only_active: assert property ( // RULE9
    @(posedge hclk) disable iff (!hresetn)
    (src_rise == 9'h010 && !wr_go) |=>
      reset_cause_status == ($past(reset_cause_status) | 9'h010))
    else $error("Unrelated cause flag changed");
  chk_sw_write: assert property ( // RULE6
    @(posedge hclk) disable iff (!hresetn)
    (wr_go && hit(req.addr, `OFS_CAUSE) && src_rise == '0) |=>
      reset_cause_status == $past(hwdata[8:0]))
    else $error("Software write to cause flags lost");
  chk_sw_no_reset: assert property ( // RULE7
    @(posedge hclk) disable iff (!hresetn)
    (wr_go && state == ST_RUN && !any_src) |=> !master_system_reset)
    else $error("Software write caused a reset");
  chk_por_flags: assert property ( // RULE5
    @(posedge hclk) $rose(hresetn) |->
      reset_cause_status[8:2] == 7'h0 || $past(src_rise) != '0)
    else $error("Power-on flags wrong");
  chk_hold_reset: assert property ( // RULE3
    @(posedge hclk) disable iff (!hresetn)
    $fell(any_src) |-> master_system_reset [*3])
    else $error("Reset not stretched after sources drop");
  chk_irq_level: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (|(irq_stat & irq_mask)) |=> irq)
    else $error("Interrupt missing for unmasked flag");

  // Power-on source handling
  chk_por_source: assert property ( // RULE5
    @(posedge hclk) disable iff (!hresetn)
    src_rise[`POS_POR] |=> reset_cause_status[1:0] == 2'h3)
    else $error("Power-on source did not set low flags");

  chk_por_clears: assert property ( // RULE5
    @(posedge hclk) disable iff (!hresetn)
    (src_rise == 9'h001) |=> reset_cause_status == `CAUSE_POR_VAL)
    else $error("Power-on source left other flags set");

  // One cause flag per source
  chk_pin_cause: assert property ( // RULE4
    @(posedge hclk) disable iff (!hresetn)
    src_rise[`POS_PIN] |=> reset_cause_status[`POS_PIN])
    else $error("Pin cause flag not set");

  chk_brownout_cause: assert property ( // RULE4
    @(posedge hclk) disable iff (!hresetn)
    src_rise[`POS_BROWNOUT] |=> reset_cause_status[`POS_BROWNOUT])
    else $error("Brown-out cause flag not set");

  chk_instr_cause: assert property ( // RULE4
    @(posedge hclk) disable iff (!hresetn)
    src_rise[`POS_INSTR] |=> reset_cause_status[`POS_INSTR])
    else $error("Instruction cause flag not set");

  chk_cfgmis_cause: assert property ( // RULE4
    @(posedge hclk) disable iff (!hresetn)
    src_rise[`POS_CFGMIS] |=> reset_cause_status[`POS_CFGMIS])
    else $error("Config mismatch cause flag not set");

  chk_trap_cause: assert property ( // RULE4
    @(posedge hclk) disable iff (!hresetn)
    src_rise[`POS_TRAP] |=> reset_cause_status[`POS_TRAP])
    else $error("Trap conflict cause flag not set");

  chk_illop_cause: assert property ( // RULE4
    @(posedge hclk) disable iff (!hresetn)
    src_rise[`POS_ILLOP] |=> reset_cause_status[`POS_ILLOP])
    else $error("Illegal opcode cause flag not set");

  chk_uwreg_cause: assert property ( // RULE4
    @(posedge hclk) disable iff (!hresetn)
    src_rise[`POS_UWREG] |=> reset_cause_status[`POS_UWREG])
    else $error("Uninitialised register cause flag not set");

  chk_rise_single: assert property ( // RULE4
    @(posedge hclk) disable iff (!hresetn)
    (src_rise != '0) |=> (src_rise & $past(src_rise)) == '0)
    else $error("Source edge reported twice");

  // Sequencer and reset output
  chk_not_run_reset: assert property ( // RULE2
    @(posedge hclk) disable iff (!hresetn)
    (state != ST_RUN) |-> master_system_reset)
    else $error("Master reset low outside run state");

  chk_release_quiet: assert property ( // RULE2
    @(posedge hclk) disable iff (!hresetn)
    $fell(master_system_reset) |-> !$past(any_src))
    else $error("Master reset released with source active");

  chk_stretch_full: assert property ( // RULE2
    @(posedge hclk) disable iff (!hresetn)
    $fell(any_src) |-> master_system_reset [*5])
    else $error("Master reset stretch cut short");

  chk_stretch_end: assert property ( // RULE2
    @(posedge hclk) disable iff (!hresetn)
    $fell(any_src) ##0 (!any_src) [*5] |=> !master_system_reset)
    else $error("Master reset stretch too long");

  // Flag storage and register side
  chk_flags_hold: assert property ( // RULE9
    @(posedge hclk) disable iff (!hresetn)
    (src_rise == '0 && !(wr_go && hit(req.addr, `OFS_CAUSE))) |=>
      $stable(reset_cause_status))
    else $error("Cause flags changed with no event");

  chk_stat_sticky: assert property ( // RULE4
    @(posedge hclk) disable iff (!hresetn)
    (src_rise == '0 && !(wr_go && hit(req.addr, `OFS_IRQ_STAT))) |=>
      $stable(irq_stat))
    else $error("Event status changed with no event");

  chk_stat_w1c: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (wr_go && hit(req.addr, `OFS_IRQ_STAT) && src_rise == '0) |=>
      irq_stat == ($past(irq_stat) & ~$past(hwdata[8:0])))
    else $error("Event status write-one clear wrong");

  chk_irq_quiet: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (irq_mask == '0) |=> !irq)
    else $error("Interrupt raised with all events masked");

  chk_mask_hold: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !(wr_go && hit(req.addr, `OFS_IRQ_MASK)) |=> $stable(irq_mask))
    else $error("Mask changed without a write");

  chk_ctrl_hold: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !(wr_go && hit(req.addr, `OFS_CONTROL)) |=> $stable(control))
    else $error("Control word changed without a write");

  chk_rdata_hold: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !(hready && hsel && htrans[1] && !hwrite) |=> $stable(hrdata))
    else $error("Read data changed without a read");

endmodule

//--- test/reset_source_model.sv
// Model of the reset source generators that feed the combiner.
// Assumes the bench calls drive() and that sources are plain levels.
`timescale 1ns/100ps
module reset_source_model (
  // Clock used to time source changes
  input  wire logic       hclk,
  // Raw sources toward the combiner, active high
  output logic      [8:0] sources
);
  initial sources = 9'h000;
  // one level per source
  // Changes land just after an edge so the sync flops never race
  task automatic drive(input int idx, input logic lvl);
    @(posedge hclk);
    sources[idx] <= lvl;
  endtask
endmodule

//--- test/reset_source_combiner_bench.sv
// Self-checking bench for the reset source combiner.
// Assumes the source model beside it and a zero-wait AHB-Lite slave.
`timescale 1ns/100ps
`include "reset_combiner_cfg.svh"
`define CHK(g, w) begin n_compared++; if ((g) !== (w)) begin bad_count++; \
  $display("unexpected at %0t: got %h want %h", $time, g, w); end end
module reset_source_combiner_bench;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd;
  logic [8:0]  exp_flags;
  logic        irq_a;
  wire  [8:0]  sources;
  wire  [31:0] hrdata;
  wire         hreadyout;
  wire         hresp;
  wire         master_system_reset;
  wire         irq;
  int          bad_count = 0;
  int          n_compared = 0;
  int          cycles = 0;

  reset_source_model reset_source_model_inst (.hclk(hclk), .sources(sources));
  reset_source_combiner reset_source_combiner_inst (
    .hclk(hclk), .hresetn(hresetn), .reset_sources(sources), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp),
    .master_system_reset(master_system_reset), .irq(irq));

  // Clock, 100 ns period
  always #50 hclk = ~hclk;

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      test_done;
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask

  // One single-word AHB-Lite transfer, waits on hready in both phases
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rdv);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask

  // Power-on: flags come back as brown-out and power-on only
  task automatic t_por;
    @(posedge hclk);
    hresetn <= 1'b0;
    tick(12);
    hresetn <= 1'b1;
    tick(8);
    `CHK(master_system_reset, 1'b0)
    bus(1'b0, `OFS_CAUSE, 32'h0, rd);
    `CHK(rd, {23'h0, `CAUSE_POR_VAL})
  endtask

  // Each source in turn: reset follows it, its flag joins the others
  task automatic t_sources;
    bus(1'b1, `OFS_CAUSE, 32'h0, rd);
    exp_flags = 9'h000;
    for (int i = 0; i < 9; i++) begin
      reset_source_model_inst.drive(i, 1'b1);
      tick(4);
      `CHK(master_system_reset, 1'b1)
      reset_source_model_inst.drive(i, 1'b0);
      tick(8);
      `CHK(master_system_reset, 1'b0)
      if (i == `POS_POR) exp_flags = `CAUSE_POR_VAL;
      else exp_flags[i] = 1'b1;
      bus(1'b0, `OFS_CAUSE, 32'h0, rd);
      `CHK(rd, {23'h0, exp_flags})
    end
  endtask

  // Software sets and clears every flag without any reset
  task automatic t_soft;
    bus(1'b1, `OFS_CAUSE, 32'h1ff, rd);
    tick(6);
    `CHK(master_system_reset, 1'b0)
    bus(1'b0, `OFS_CAUSE, 32'h0, rd);
    `CHK(rd, 32'h1ff)
    bus(1'b1, `OFS_CAUSE, 32'h0, rd);
    bus(1'b0, `OFS_CAUSE, 32'h0, rd);
    `CHK(rd, 32'h0)
    bus(1'b0, 12'h100, 32'h0, rd);
    `CHK(rd, 32'h0)
    `CHK({hreadyout, hresp}, 2'b10)
  endtask

  // Event status, mask in both polarities, write-one clear
  // A set mask bit passes the event, a clear one blocks it
  task automatic t_irq;
    bus(1'b1, `OFS_IRQ_STAT, 32'h1ff, rd);
    bus(1'b1, `OFS_IRQ_MASK, 32'h0, rd);
    reset_source_model_inst.drive(`POS_WDOG, 1'b1);
    reset_source_model_inst.drive(`POS_WDOG, 1'b0);
    tick(8);
    bus(1'b0, `OFS_IRQ_STAT, 32'h0, rd);
    `CHK(rd, 32'h010)
    irq_a = irq;
    bus(1'b1, `OFS_IRQ_MASK, 32'h1ff, rd);
    tick(2);
    `CHK(irq_a, 1'b0)
    `CHK(irq, 1'b1)
    bus(1'b1, `OFS_IRQ_STAT, 32'h010, rd);
    tick(2);
    `CHK(irq, 1'b0)
    bus(1'b1, `OFS_IRQ_MASK, 32'h0, rd);
    tick(2);
    `CHK(irq, 1'b0)
  endtask

  task automatic test_done;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Main sequence, ending with a second power-on over set flags
  initial begin
    t_por;
    t_sources;
    t_soft;
    t_irq;
    bus(1'b1, `OFS_CAUSE, 32'h1fc, rd);
    t_por;
    test_done;
  end
endmodule
